// [hdl/pidreg_pkg.sv]
package pidreg_pkg;
    // ==================================================
    // Bus and register map
    // ==================================================
    localparam int unsigned ADR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] VOLT_LO_OFS = 8'h08;
    localparam logic [7:0] VOLT_HI_OFS = 8'h0C;
    localparam logic [7:0] CUR_LO_OFS = 8'h10;
    localparam logic [7:0] CUR_HI_OFS = 8'h14;
    localparam logic [7:0] MAX_FREQ_OFS = 8'h18;
    localparam logic [7:0] FREQ_CMD_OFS = 8'h1C;
    localparam logic [7:0] PID_OUT_OFS = 8'h20;
    localparam logic [7:0] ERROR_OFS = 8'h24;
    // Loop sets: adr[7:6] 1 = loop 1, 2 = loop 2; adr[5:2] = field
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_LOOP_BIT = 1;
    localparam int unsigned STAT_LIMIT_BIT = 0;
    localparam int unsigned STAT_ACTIVE_BIT = 1;
    // ==================================================
    // Loop set fields
    // ==================================================
    localparam int unsigned NUM_FIELDS = 11;
    localparam logic [3:0] F_REF_SRC = 4'h0;
    localparam logic [3:0] F_FB_SRC = 4'h1;
    localparam logic [3:0] F_SETPOINT = 4'h2;
    localparam logic [3:0] F_TRIM_SEL = 4'h3;
    localparam logic [3:0] F_DEADBAND = 4'h4;
    localparam logic [3:0] F_PRELOAD = 4'h5;
    localparam logic [3:0] F_TRIM_HI = 4'h6;
    localparam logic [3:0] F_TRIM_LO = 4'h7;
    localparam logic [3:0] F_PGAIN = 4'h8;
    localparam logic [3:0] F_ITIME = 4'h9;
    localparam logic [3:0] F_DRATE = 4'hA;
    // Source codes for reference and feedback
    localparam logic [15:0] SRC_SETPOINT = 16'h0000;
    localparam logic [15:0] SRC_VOLT = 16'h0001;
    localparam logic [15:0] SRC_CUR = 16'h0002;
    // ==================================================
    // Units: percent 0.1 %, freq 0.01 Hz, gain 0.01, time 0.1 s
    // ==================================================
    localparam logic signed [15:0] PCT_FULL = 16'sh03E8;
    localparam logic signed [47:0] GAIN_ONE = 48'sh0000_0000_0064;
    localparam logic signed [47:0] I_SCALE = 48'sh0000_0001_86A0;
    localparam logic signed [47:0] I_TIME_DIV = 48'sh0000_0000_03E8;
    localparam logic [11:0] VOLT_FULL = 12'h7FF;
    localparam logic [11:0] CUR_FULL = 12'hFFF;
    localparam logic signed [47:0] SAT_MAX = 48'sh0000_0000_7FFF;
    localparam logic signed [47:0] SAT_MIN = 48'shFFFF_FFFF_8000;
    // ==================================================
    // Reset values
    // ==================================================
    localparam logic [15:0] VOLT_LO_RST = 16'h0000;
    localparam logic [15:0] VOLT_HI_RST = 16'h03E8;
    localparam logic [15:0] CUR_LO_RST = 16'h0000;
    localparam logic [15:0] CUR_HI_RST = 16'h03E8;
    localparam logic [15:0] MAX_FREQ_RST = 16'h1770;
    localparam logic [15:0] PGAIN_RST = 16'h0064;
    localparam logic [15:0] ITIME_RST = 16'h0014;
    localparam logic [15:0] TRIM_HI_RST = 16'h1770;
    localparam logic [15:0] DRATE_RST = 16'h0000;
    // ==================================================
    // Timing
    // ==================================================
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned SAMPLE_US = 1000;
    localparam int unsigned SAMPLE_CYC_DEF = SAMPLE_US * CLK_MHZ;
    localparam logic signed [47:0] SAMPLE_US_S = 48'(SAMPLE_US);
endpackage : pidreg_pkg

// [hdl/pidreg_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// - Analog input maps to percent via programmable low and high scale points.
// - Low above high inverts the mapping, maximum input gives zero percent.
// - Error within plus or minus deadband is treated as zero.
// - Start or enable loads preload frequency into integral accumulator.
// - Output steps to preload frequency at start; with integral time nonzero, regulation continues from there.
// - Trim mode only: output clamped between trim upper and lower limits.
// - Integral accumulator stops only growth toward a limit while output sits on it.
// - Proportional term is error times gain; gain 1 at 100% gives full frequency.
// - Proportional gain zero removes proportional term.
// - Integral reaches full frequency after integral time at constant 100% error.
// - Integral time zero disables integral term.
// - Differential term is rate times previous error minus current error.
// - Rate 1.00 gives 0.1% max frequency at 1% per second error change.
// - Rate zero disables differential term; zero is its reset value.
// - Trim select zero: output is whole command; else added to speed reference.
// - Negative voltage input is treated as zero.
// - Two loop settings sets held, only the selected one active.
module pidreg_top
    import pidreg_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC_DEF
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lane selects
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic signed [11:0] volt_input, // Bipolar voltage sample
    input wire logic [11:0] current_input, // Current loop sample
    input wire logic signed [15:0] speed_reference, // Ramped speed ref
    input wire logic start_event, // Drive start pulse
    output logic signed [15:0] freq_command, // Frequency command
    output logic pid_active, // Regulator enabled
    output logic pid_at_limit // Output on a limit
);
    // ==================================================
    // Elaboration check
    // ==================================================
    if (SAMPLE_CYCLES < 2) begin : g_chk
        $error("SAMPLE_CYCLES must be at least 2");
    end

    // ==================================================
    // Helpers
    // ==================================================
    function automatic logic signed [47:0] zx(input logic [15:0] v);
        return $signed({32'h0000_0000, v});
    endfunction : zx

    function automatic logic signed [47:0] sx(input logic [15:0] v);
        return 48'($signed(v));
    endfunction : sx

    // Saturate a wide sum to the signed output range
    function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
        if (v > SAT_MAX) begin
            return SAT_MAX[15:0];
        end else if (v < SAT_MIN) begin
            return SAT_MIN[15:0];
        end
        return v[15:0];
    endfunction : sat16

    // Raw converter count to percent of full range
    function automatic logic signed [15:0] pct_of(input logic [11:0] raw,
                                                 input logic [11:0] full);
        logic signed [47:0] num;
        num = zx({4'h0, raw}) * sx(PCT_FULL);
        return 16'(num / zx({4'h0, full}));
    endfunction : pct_of

    // Map percent through low and high points, clamp to 0..100 %
    function automatic logic signed [15:0] scale(input logic signed [15:0] pct,
                                                input logic [15:0] lo,
                                                input logic [15:0] hi);
        logic signed [47:0] v;
        v = 48'sh0000_0000_0000;
        if (hi != lo) begin
            v = ((sx(pct) - zx(lo)) * sx(PCT_FULL)) / (zx(hi) - zx(lo));
        end
        if (v < 48'sh0000_0000_0000) begin
            v = 48'sh0000_0000_0000;
        end else if (v > sx(PCT_FULL)) begin
            v = sx(PCT_FULL);
        end
        return v[15:0];
    endfunction : scale

    // ==================================================
    // State
    // ==================================================
    logic [15:0] ctrl_reg, ctrl_next;
    logic [15:0] volt_lo_reg, volt_lo_next, volt_hi_reg, volt_hi_next;
    logic [15:0] cur_lo_reg, cur_lo_next, cur_hi_reg, cur_hi_next;
    logic [15:0] fmax_reg, fmax_next;
    logic [15:0] loop_reg [0:1][0:NUM_FIELDS-1];
    logic [15:0] loop_next [0:1][0:NUM_FIELDS-1];
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic [31:0] cnt_reg, cnt_next;
    logic en_d_reg, en_d_next;
    logic signed [47:0] acc_reg, acc_next;
    logic signed [15:0] err_prev_reg, err_prev_next;
    logic signed [15:0] err_reg, err_next;
    logic signed [15:0] out_reg, out_next;
    logic signed [15:0] cmd_reg, cmd_next;
    logic limit_reg, limit_next;

    // ==================================================
    // Signal path
    // ==================================================
    logic ls, enable, trim, tick, start, at_limit, wr, at_hi, at_lo, hold_i;
    logic signed [15:0] volt_pct, cur_pct, ref_pct, fb_pct, err, err_eff;
    logic signed [15:0] sum_sat, limited, lim_hi, lim_lo;
    logic signed [47:0] p_term, i_term, i_inc, d_term, sum;
    logic [15:0] mag;

    // Source select for reference or feedback
    function automatic logic signed [15:0] src_pct(input logic [15:0] sel,
                                                  input logic [15:0] setp,
                                                  input logic signed [15:0] vp,
                                                  input logic signed [15:0] cp);
        case (sel)
            SRC_SETPOINT: return $signed(setp);
            SRC_VOLT: return vp;
            SRC_CUR: return cp;
            default: return 16'sh0000;
        endcase
    endfunction : src_pct

    // Error and the three terms from the selected set
    always_comb begin
        enable = ctrl_reg[CTRL_EN_BIT];
        ls = ctrl_reg[CTRL_LOOP_BIT];
        volt_pct = volt_input[11] ? 16'sh0000 : pct_of(volt_input, VOLT_FULL);
        cur_pct = pct_of(current_input, CUR_FULL);
        volt_pct = scale(volt_pct, volt_lo_reg, volt_hi_reg);
        cur_pct = scale(cur_pct, cur_lo_reg, cur_hi_reg);
        ref_pct = src_pct(loop_reg[ls][F_REF_SRC], loop_reg[ls][F_SETPOINT],
                          volt_pct, cur_pct);
        fb_pct = src_pct(loop_reg[ls][F_FB_SRC], loop_reg[ls][F_SETPOINT],
                         volt_pct, cur_pct);
        err = ref_pct - fb_pct;
        mag = err[15] ? 16'(-err) : err;
        err_eff = (mag <= loop_reg[ls][F_DEADBAND]) ? 16'sh0000 : err;
        p_term = (sx(err_eff) * zx(loop_reg[ls][F_PGAIN]) * zx(fmax_reg))
                 / (sx(PCT_FULL) * GAIN_ONE);
        if (loop_reg[ls][F_ITIME] == 16'h0000) begin
            i_inc = 48'sh0000_0000_0000;
            i_term = 48'sh0000_0000_0000;
        end else begin
            i_inc = (sx(err_eff) * zx(fmax_reg) * SAMPLE_US_S)
                    / (zx(loop_reg[ls][F_ITIME]) * I_TIME_DIV);
            i_term = acc_reg / I_SCALE;
        end
        // differential on error step
        // Rate and error units cancel, leaving only the sample period
        d_term = (zx(loop_reg[ls][F_DRATE]) * (sx(err_prev_reg) - sx(err_eff))
                  * zx(fmax_reg)) / SAMPLE_US_S;
        sum = p_term + i_term + d_term;
        sum_sat = sat16(sum);
        // trim limits apply only in trim mode
        trim = loop_reg[ls][F_TRIM_SEL] != 16'h0000;
        lim_hi = $signed(loop_reg[ls][F_TRIM_HI]);
        lim_lo = $signed(loop_reg[ls][F_TRIM_LO]);
        limited = sum_sat;
        at_hi = sum > SAT_MAX;
        at_lo = sum < SAT_MIN;
        if (trim && sum_sat >= lim_hi) begin
            limited = lim_hi;
            at_hi = 1'b1;
        end else if (trim && sum_sat <= lim_lo) begin
            limited = lim_lo;
            at_lo = 1'b1;
        end
        at_limit = at_hi || at_lo;
        // Freeze only growth into a limit, else the loop could never leave it
        hold_i = (at_hi && i_inc > 48'sh0000_0000_0000)
                 || (at_lo && i_inc < 48'sh0000_0000_0000);
    end

    // Sample timer, start detection and loop state
    always_comb begin
        tick = cnt_reg == 32'(SAMPLE_CYCLES - 1);
        start = enable && (start_event || !en_d_reg);
        en_d_next = enable;
        cnt_next = tick ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
        acc_next = acc_reg;
        err_prev_next = err_prev_reg;
        err_next = err_reg;
        out_next = out_reg;
        limit_next = limit_reg;
        if (!enable) begin
            out_next = 16'sh0000;
            limit_next = 1'b0;
        end else if (start) begin
            acc_next = sx(loop_reg[ls][F_PRELOAD]) * I_SCALE;
            out_next = $signed(loop_reg[ls][F_PRELOAD]);
            err_prev_next = err_eff;
            err_next = err;
            cnt_next = 32'h0000_0000;
        end else if (tick) begin
            if (!hold_i) begin
                acc_next = acc_reg + i_inc;
            end
            out_next = limited;
            err_prev_next = err_eff;
            err_next = err;
            limit_next = at_limit;
        end
        if (!enable) begin
            cmd_next = speed_reference;
        end else if (trim) begin
            cmd_next = sat16(sx(speed_reference) + sx(out_reg));
        end else begin
            cmd_next = out_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0000_0000;
            en_d_reg <= 1'b0;
            acc_reg <= 48'sh0000_0000_0000;
            err_prev_reg <= 16'sh0000;
            err_reg <= 16'sh0000;
            out_reg <= 16'sh0000;
            cmd_reg <= 16'sh0000;
            limit_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            en_d_reg <= en_d_next;
            acc_reg <= acc_next;
            err_prev_reg <= err_prev_next;
            err_reg <= err_next;
            out_reg <= out_next;
            cmd_reg <= cmd_next;
            limit_reg <= limit_next;
        end
    end

    // ==================================================
    // Wishbone slave, one wait state, unmapped reads zero
    // ==================================================
    function automatic logic [15:0] lanes(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : lanes

    always_comb begin
        ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
        wr = ack_next && wb_we_i;
        ctrl_next = ctrl_reg;
        volt_lo_next = volt_lo_reg;
        volt_hi_next = volt_hi_reg;
        cur_lo_next = cur_lo_reg;
        cur_hi_next = cur_hi_reg;
        fmax_next = fmax_reg;
        loop_next = loop_reg;
        rdat_next = rdat_reg;
        if (wr) begin
            case (wb_adr_i)
                CTRL_OFS: ctrl_next = lanes(ctrl_reg, wb_dat_i, wb_sel_i) & 16'h0003;
                VOLT_LO_OFS: volt_lo_next = lanes(volt_lo_reg, wb_dat_i, wb_sel_i);
                VOLT_HI_OFS: volt_hi_next = lanes(volt_hi_reg, wb_dat_i, wb_sel_i);
                CUR_LO_OFS: cur_lo_next = lanes(cur_lo_reg, wb_dat_i, wb_sel_i);
                CUR_HI_OFS: cur_hi_next = lanes(cur_hi_reg, wb_dat_i, wb_sel_i);
                MAX_FREQ_OFS: fmax_next = lanes(fmax_reg, wb_dat_i, wb_sel_i);
                default: begin
                    if ((wb_adr_i[7] ^ wb_adr_i[6]) && wb_adr_i[5:2] < 4'(NUM_FIELDS))
                    begin
                        loop_next[wb_adr_i[7]][wb_adr_i[5:2]] = lanes(
                            loop_reg[wb_adr_i[7]][wb_adr_i[5:2]], wb_dat_i, wb_sel_i);
                    end
                end
            endcase
        end
        if (ack_next) begin
            rdat_next = 32'h0000_0000;
            case (wb_adr_i)
                CTRL_OFS: rdat_next[15:0] = ctrl_reg;
                STATUS_OFS: rdat_next[1:0] = {enable, limit_reg};
                VOLT_LO_OFS: rdat_next[15:0] = volt_lo_reg;
                VOLT_HI_OFS: rdat_next[15:0] = volt_hi_reg;
                CUR_LO_OFS: rdat_next[15:0] = cur_lo_reg;
                CUR_HI_OFS: rdat_next[15:0] = cur_hi_reg;
                MAX_FREQ_OFS: rdat_next[15:0] = fmax_reg;
                FREQ_CMD_OFS: rdat_next[15:0] = cmd_reg;
                PID_OUT_OFS: rdat_next[15:0] = out_reg;
                ERROR_OFS: rdat_next[15:0] = err_reg;
                default: begin
                    if ((wb_adr_i[7] ^ wb_adr_i[6]) && wb_adr_i[5:2] < 4'(NUM_FIELDS))
                    begin
                        rdat_next[15:0] = loop_reg[wb_adr_i[7]][wb_adr_i[5:2]];
                    end
                end
            endcase
        end
    end

    // Register file; rate resets to zero so D starts disabled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            ctrl_reg <= 16'h0000;
            volt_lo_reg <= VOLT_LO_RST;
            volt_hi_reg <= VOLT_HI_RST;
            cur_lo_reg <= CUR_LO_RST;
            cur_hi_reg <= CUR_HI_RST;
            fmax_reg <= MAX_FREQ_RST;
            for (int l = 0; l < 2; l++) begin
                for (int f = 0; f < NUM_FIELDS; f++) begin
                    loop_reg[l][f] <= 16'h0000;
                end
                loop_reg[l][F_PGAIN] <= PGAIN_RST;
                loop_reg[l][F_ITIME] <= ITIME_RST;
                loop_reg[l][F_TRIM_HI] <= TRIM_HI_RST;
                loop_reg[l][F_DRATE] <= DRATE_RST;
            end
        end else begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            ctrl_reg <= ctrl_next;
            volt_lo_reg <= volt_lo_next;
            volt_hi_reg <= volt_hi_next;
            cur_lo_reg <= cur_lo_next;
            cur_hi_reg <= cur_hi_next;
            fmax_reg <= fmax_next;
            loop_reg <= loop_next;
        end
    end

    // Outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign freq_command = cmd_reg;
    assign pid_active = ctrl_reg[CTRL_EN_BIT];
    assign pid_at_limit = limit_reg;
endmodule : pidreg_top
`default_nettype wire

// [verification/pidreg_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module pidreg_monitor
    import pidreg_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic rst_n, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [ADR_W-1:0] wb_adr_i, // Address
    input wire logic [3:0] wb_sel_i, // Lanes
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire logic signed [11:0] volt_input, // Voltage
    input wire logic [11:0] current_input, // Current
    input wire logic signed [15:0] speed_reference, // Speed ref
    input wire logic start_event, // Start
    input wire logic signed [15:0] freq_command, // Command
    input wire logic pid_active, // Active
    input wire logic pid_at_limit // On limit
);
    // ==================================================
    // Bus handshake
    // ==================================================
    default clocking mcb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_idle3;
        !pid_active [*3];
    endsequence
    // One wait state, then a single pulse
    a_ack_wait: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // Upper half reads as zero
    a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    // Quiet outputs right after reset
    a_reset_quiet: assert property ($rose(rst_n) |-> !wb_ack_o && !pid_active
        && freq_command == 16'sh0000) else $error("outputs not quiet");
    // Enable moves only after a control write
    a_enable_cause: assert property ($changed(pid_active) |->
        wb_ack_o && wb_we_i && wb_adr_i == CTRL_OFS) else $error("stray enable");
    // ==================================================
    // Regulator outputs
    // ==================================================
    a_idle_track: assert property (s_idle3 |-> freq_command == $past(speed_reference))
        else $error("disabled command not speed ref");
    a_limit_idle: assert property (!pid_active [*2] |-> !pid_at_limit)
        else $error("limit flag while disabled");
endmodule : pidreg_monitor
`default_nettype wire

// [verification/test_pidreg_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_pidreg_top
    import pidreg_pkg::*;
;
    // Short sample period keeps the run brief
    localparam int SC = 10;
    logic clock, rst_n, cyc, stb, we, ack, start, act, lim;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r, rd;
    logic signed [11:0] volt;
    logic [11:0] cur;
    logic signed [15:0] spd, freq, fa;
    logic [15:0] lp [11];
    int bad_count, samples_checked, n;
    // Exclusive-mode table: source, inputs, scale, deadband, gain, command
    logic [15:0] t_fs [8] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h2, 16'h2};
    logic [11:0] t_vin [8] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'hC00, 12'h400, 12'h0, 12'h0};
    logic [11:0] t_cur [8] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'hFFF, 12'h0};
    logic [15:0] t_vhi [8] = '{16'h3E8, 16'h3E8, 16'h3E8, 16'h3E8, 16'h3E8, 16'h1F4, 16'h3E8, 16'h3E8};
    logic [15:0] t_clo [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3E8, 16'h3E8};
    logic [15:0] t_chi [8] = '{16'h3E8, 16'h3E8, 16'h3E8, 16'h3E8, 16'h3E8, 16'h3E8, 16'h0, 16'h0};
    logic [15:0] t_db [8] = '{16'h0, 16'h0, 16'h1F4, 16'h1F3, 16'h0, 16'h0, 16'h0, 16'h0};
    logic [15:0] t_gn [8] = '{16'h64, 16'h0, 16'h64, 16'h64, 16'h64, 16'h64, 16'h64, 16'h64};
    logic [15:0] t_ex [8] = '{16'hBB8, 16'h0, 16'h0, 16'hBB8, 16'hBB8, 16'hF448, 16'hBB8, 16'hF448};

    pidreg_top #(.SAMPLE_CYCLES(SC)) DUT (
        .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .volt_input(volt), .current_input(cur), .speed_reference(spd), .start_event(start),
        .freq_command(freq), .pid_active(act), .pid_at_limit(lim)
    );

    // 125 MHz clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ==================================================
    // Shared tasks
    // ==================================================
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task fchk(input logic [15:0] e);
        check({16'h0000, freq}, {16'h0000, e});
    endtask : fchk
    // Classic cycle: hold until ack is seen, release after that edge
    task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int k;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {16'h0000, d};
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (ack !== 1'b1 && k < 40);
        if (ack !== 1'b1) begin
            bad_count++;
            wrap_up();
        end
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 16'h0000);
        check(rd, e);
    endtask : rdc
    // Disable, load a loop set from lp, then apply control word
    task run(input logic [7:0] b, input logic [15:0] c);
        wr(CTRL_OFS, 16'h0000);
        for (int f = 0; f < 11; f++) wr(b + 8'(4 * f), lp[f]);
        wr(CTRL_OFS, c);
    endtask : run
    task settle;
        repeat (4 * SC + 6) @(negedge clock);
    endtask : settle
    // ==================================================
    // Main sequence
    // ==================================================
    initial begin
        {cyc, stb, we, start, rst_n} = 5'h00;
        adr = 8'h00;
        sel = 4'hF;
        dat_w = 32'h0000_0000;
        {volt, cur} = 24'h00_0000;
        spd = 16'sh0064;
        bad_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdc(VOLT_HI_OFS, 32'h0000_03E8);
        rdc(MAX_FREQ_OFS, 32'h0000_1770);
        rdc(8'h68, 32'h0000_0000);
        rdc(8'h60, 32'h0000_0064);
        wr(8'hFC, 16'h1234);
        rdc(8'hFC, 32'h0000_0000);
        fchk(16'h0064);
        for (int i = 0; i < 8; i++) begin
            wr(VOLT_HI_OFS, t_vhi[i]);
            wr(CUR_LO_OFS, t_clo[i]);
            wr(CUR_HI_OFS, t_chi[i]);
            volt <= t_vin[i];
            cur <= t_cur[i];
            lp = '{16'h0, t_fs[i], 16'h1F4, 16'h0, t_db[i], 16'h0, 16'h1770, 16'h0, t_gn[i],
                16'h0, 16'h0};
            run(8'h40, 16'h0001);
            settle();
            fchk(t_ex[i]);
            if (i == 0) rdc(ERROR_OFS, 32'h0000_01F4);
        end
        @(posedge clock);
        volt <= 12'h000;
        lp = '{16'h0, 16'h1, 16'h3E8, 16'h0, 16'h0, 16'h4D2, 16'h1770, 16'h0, 16'h0, 16'h0, 16'h0};
        run(8'h40, 16'h0001);
        repeat (5) @(negedge clock);
        fchk(16'h04D2);
        settle();
        fchk(16'h0000);
        lp[5] = 16'h0000;
        lp[9] = 16'h000A;
        run(8'h40, 16'h0001);
        settle();
        fa = freq;
        repeat (SC) @(negedge clock);
        check({16'h0000, 16'(freq - fa)}, 32'h0000_0006);
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (3) @(negedge clock);
        fchk(16'h0000);
        // differential kick on a setpoint step
        lp = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1770, 16'h0, 16'h0, 16'h0, 16'h64};
        run(8'h40, 16'h0001);
        settle();
        fchk(16'h0000);
        wr(8'h48, 16'h000A);
        for (n = 0; n < 40 && freq === 16'sh0000; n++) @(negedge clock);
        if (n == 40) begin
            bad_count++;
            wrap_up();
        end
        fchk(16'hE890);
        repeat (SC) @(negedge clock);
        fchk(16'h0000);
        lp = '{16'h0, 16'h1, 16'h3E8, 16'h1, 16'h0, 16'h0, 16'h1E, 16'hFFEC, 16'h0, 16'hA, 16'h0};
        run(8'h40, 16'h0001);
        repeat (20 * SC) @(negedge clock);
        fchk(16'h0082);
        check({31'h0, lim}, 32'h0000_0001);
        @(posedge clock);
        volt <= 12'h7FF;
        wr(8'h48, 16'h0000);
        repeat (3 * SC) @(negedge clock);
        check({31'h0, lim}, 32'h0000_0000);
        repeat (20 * SC) @(negedge clock);
        fchk(16'h0050);
        @(posedge clock);
        volt <= 12'h000;
        lp = '{16'h0, 16'h1, 16'h1F4, 16'h0, 16'h0, 16'h0, 16'h1770, 16'h0, 16'h32, 16'h0, 16'h0};
        run(8'h80, 16'h0003);
        settle();
        fchk(16'h05DC);
        rdc(STATUS_OFS, 32'h0000_0002);
        wr(CTRL_OFS, 16'h0000);
        repeat (4) @(negedge clock);
        fchk(16'h0064);
        wrap_up();
    end
endmodule : test_pidreg_top

bind pidreg_top pidreg_monitor mon (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .volt_input(volt_input), .current_input(current_input),
    .speed_reference(speed_reference), .start_event(start_event),
    .freq_command(freq_command), .pid_active(pid_active), .pid_at_limit(pid_at_limit)
);
`default_nettype wire
